// [rtl/fsp_status_ctrl.sv]
// status and control register of a serial flash with write protection
// assumes serial pins from outside the clock domain, power cycle as a pulse
//
// What this block does
// - holds a 24-bit status register split into low, middle and high byte
// - write-in-progress bit is set while program, erase or status write runs
// - write-enable latch shows at bit 1; clear latch rejects every write
// - block protect bits change only by status write and select guarded region
// - program or erase into the protected region is refused
// - block protect bits are writable only outside hardware protected mode
// - chip erase runs only with low protect bits 000/cmp 0 or 111/cmp 1
// - complement set inverts the decoded protected region
// - two status-protect bits select the status register protection mode
// - protect setting 00 accepts status write whenever latch is set
// - protect setting 01 with protect pin low locks the status register
// - protect setting 01 with protect pin high accepts write with latch set
// - protect setting 10 refuses status writes until the next power cycle
// - a power cycle turns protect setting 10 back into 00
// - protect setting 11 makes the status register permanently unwritable
// - quad enable defaults to 0; set, protect and hold pins become data lanes
// - complement clear: 001 upper 1/64, 111 all, 000 nothing protected
// - latch clears on power-up, disable, status write, program, erase, reset
// - quad transfer commands only honoured with quad enable set
`timescale 1ns/1ps
module fsp_status_ctrl #(
   parameter int unsigned BUSY_CYCLES = fsp_pkg::BUSY_CYCLES_DFLT
) (
   input logic i_clock,
   input logic i_reset,
   input logic i_power_cycle,
   input logic i_sclk,
   input logic i_cs_n,
   input logic i_si,
   input logic i_wp_n,
   input logic i_hold_n,
   output logic o_so,
   output logic o_so_oe,
   output logic o_write_in_progress,
   output logic o_quad_lane_enable,
   output logic o_array_op_start,
   output logic [1:0] o_array_op_kind,
   output logic [23:0] o_array_op_addr,
   output logic [23:0] o_status
);
   // ----------------------------------------------------------------
   // pin synchronisers and filters
   // ----------------------------------------------------------------
   logic [4:0] pins;
   logic [4:0] s1_q;
   logic [4:0] s2_q;
   logic [4:0] s3_q;
   logic [4:0] filt_q;
   logic [4:0] filt_d;
   assign pins = {i_hold_n, i_wp_n, i_si, i_cs_n, i_sclk};
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         s1_q <= fsp_pkg::PIN_IDLE;
         s2_q <= fsp_pkg::PIN_IDLE;
         s3_q <= fsp_pkg::PIN_IDLE;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   for (genvar g = 0; g < fsp_pkg::PIN_COUNT; g++) begin : g_filt
      assign filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
   end
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         filt_q <= fsp_pkg::PIN_IDLE;
      end else begin
         filt_q <= filt_d;
      end
   end
   // ----------------------------------------------------------------
   // state declarations
   // ----------------------------------------------------------------
   logic wel_q;
   logic qe_q;
   logic cmp_q;
   logic [1:0] srp_q;
   logic [4:0] bp_q;
   logic [2:0] lock_q;
   logic [1:0] drv_q;
   logic armed_q;
   logic [23:0] busy_cnt_q;
   logic [2:0] bit_cnt_q;
   logic [2:0] byte_cnt_q;
   logic [2:0] out_cnt_q;
   logic [6:0] sr_q;
   logic [7:0] cmd_q;
   logic [7:0] data_q;
   logic [7:0] rd_byte_q;
   logic [23:0] addr_q;
   logic [23:0] status_w;
   logic [7:0] rx_byte;
   logic [7:0] rd_sel;
   logic hold_act;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic cs_fall;
   logic rd_active;
   fsp_prot_if prot ();
   assign prot.block_protect = bp_q;
   assign prot.protect_complement = cmp_q;
   fsp_region_decode u_decode (
      .prot(prot)
   );
   assign o_quad_lane_enable = qe_q;
   // ----------------------------------------------------------------
   // register assembly and edge detection
   // ----------------------------------------------------------------
   always_comb begin
      status_w = {1'b0, drv_q, 1'b0, 4'h0, 1'b0, cmp_q, lock_q, 1'b0, qe_q, srp_q, bp_q,
         wel_q, o_write_in_progress};
      hold_act = ~qe_q & ~filt_q[fsp_pkg::PIN_HOLD];
      sclk_rise = filt_d[fsp_pkg::PIN_SCLK] & ~filt_q[fsp_pkg::PIN_SCLK] &
         ~filt_q[fsp_pkg::PIN_CS] & ~hold_act;
      sclk_fall = ~filt_d[fsp_pkg::PIN_SCLK] & filt_q[fsp_pkg::PIN_SCLK] &
         ~filt_q[fsp_pkg::PIN_CS] & ~hold_act;
      cs_rise = filt_d[fsp_pkg::PIN_CS] & ~filt_q[fsp_pkg::PIN_CS];
      cs_fall = ~filt_d[fsp_pkg::PIN_CS] & filt_q[fsp_pkg::PIN_CS];
      rx_byte = {sr_q, s3_q[fsp_pkg::PIN_SI]};
      rd_active = (byte_cnt_q != 3'h0) & ~filt_q[fsp_pkg::PIN_CS] &
         (cmd_q == fsp_pkg::CMD_READ_SR1 || cmd_q == fsp_pkg::CMD_READ_SR2 ||
         cmd_q == fsp_pkg::CMD_READ_SR3);
      case (cmd_q)
         fsp_pkg::CMD_READ_SR2: rd_sel = status_w[15:8];
         fsp_pkg::CMD_READ_SR3: rd_sel = status_w[23:16];
         default: rd_sel = status_w[7:0];
      endcase
   end
   // ----------------------------------------------------------------
   // serial receive
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 3'h0;
         sr_q <= 7'h00;
         cmd_q <= 8'h00;
         data_q <= 8'h00;
         addr_q <= 24'h000000;
      end else if (cs_fall) begin
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 3'h0;
      end else if (sclk_rise) begin
         sr_q <= rx_byte[6:0];
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (bit_cnt_q == 3'h7) begin
            if (byte_cnt_q != 3'h7) begin
               byte_cnt_q <= byte_cnt_q + 3'h1;
            end
            case (byte_cnt_q)
               3'h0: cmd_q <= rx_byte;
               3'h1: begin
                  addr_q[23:16] <= rx_byte;
                  data_q <= rx_byte;
               end
               3'h2: addr_q[15:8] <= rx_byte;
               3'h3: addr_q[7:0] <= rx_byte;
               default: ;
            endcase
         end
      end
   end
   // ----------------------------------------------------------------
   // serial transmit of status bytes
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_so <= 1'b0;
         o_so_oe <= 1'b0;
         out_cnt_q <= 3'h0;
         rd_byte_q <= 8'h00;
      end else begin
         o_so_oe <= rd_active;
         if (cs_fall) begin
            out_cnt_q <= 3'h0;
         end else if (sclk_fall && rd_active) begin
            out_cnt_q <= out_cnt_q + 3'h1;
            if (out_cnt_q == 3'h0) begin
               rd_byte_q <= rd_sel;
               o_so <= rd_sel[7];
            end else begin
               o_so <= rd_byte_q[3'h7 - out_cnt_q];
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // command decode at frame end
   // ----------------------------------------------------------------
   logic fe;
   logic ex_wren;
   logic ex_write_disable_cmd;
   logic ex_status_write_cmd;
   logic ex_prog;
   logic ex_erase;
   logic ex_chip;
   logic ex_arm;
   logic ex_rst;
   logic ce_ok;
   logic hit;
   logic wp_high;
   logic sr_locked;
   logic idle_wel;
   logic quad_ok;
   logic op_go;
   logic sr_go;
   logic wel_clr;
   logic [23:0] mask;
   logic [23:0] op_lo;
   logic [23:0] op_hi;
   always_comb begin
      fe = cs_rise & (bit_cnt_q == 3'h0);
      ex_wren = fe & (cmd_q == fsp_pkg::CMD_WRITE_ENABLE) & (byte_cnt_q == fsp_pkg::LEN_SHORT);
      ex_write_disable_cmd = fe & (cmd_q == fsp_pkg::CMD_WRITE_DISABLE) & (byte_cnt_q == fsp_pkg::LEN_SHORT);
      ex_status_write_cmd = fe & (byte_cnt_q >= fsp_pkg::LEN_SR_WRITE) &
         (cmd_q == fsp_pkg::CMD_WRITE_SR1 || cmd_q == fsp_pkg::CMD_WRITE_SR2 ||
         cmd_q == fsp_pkg::CMD_WRITE_SR3);
      ex_prog = fe & (byte_cnt_q >= fsp_pkg::LEN_PROG) &
         (cmd_q == fsp_pkg::CMD_PAGE_WRITE || cmd_q == fsp_pkg::CMD_QUAD_PAGE_WRITE ||
         cmd_q == fsp_pkg::CMD_FAST_PAGE_WRITE);
      ex_erase = fe & (byte_cnt_q == fsp_pkg::LEN_ERASE) &
         (cmd_q == fsp_pkg::CMD_SECTOR_WIPE || cmd_q == fsp_pkg::CMD_BLOCK32_WIPE ||
         cmd_q == fsp_pkg::CMD_BLOCK64_WIPE);
      ex_chip = fe & (byte_cnt_q == fsp_pkg::LEN_SHORT) &
         (cmd_q == fsp_pkg::CMD_CHIP_WIPE_A || cmd_q == fsp_pkg::CMD_CHIP_WIPE_B);
      ex_arm = fe & (cmd_q == fsp_pkg::CMD_RESET_ARM) & (byte_cnt_q == fsp_pkg::LEN_SHORT);
      ex_rst = fe & armed_q & (cmd_q == fsp_pkg::CMD_RESET_GO) &
         (byte_cnt_q == fsp_pkg::LEN_SHORT);
      ce_ok = (bp_q[2:0] == 3'h0 && !cmp_q) || (bp_q[2:0] == 3'h7 && cmp_q);
      case (cmd_q)
         fsp_pkg::CMD_SECTOR_WIPE: mask = fsp_pkg::MASK_SECTOR;
         fsp_pkg::CMD_BLOCK32_WIPE: mask = fsp_pkg::MASK_BLOCK32;
         fsp_pkg::CMD_BLOCK64_WIPE: mask = fsp_pkg::MASK_BLOCK64;
         default: mask = fsp_pkg::MASK_PAGE;
      endcase
      op_lo = addr_q & ~mask;
      op_hi = addr_q | mask;
      hit = prot.prot_en && op_lo <= prot.prot_hi && prot.prot_lo <= op_hi;
      wp_high = qe_q | filt_q[fsp_pkg::PIN_WP];
      sr_locked = srp_q[1] | ((srp_q == fsp_pkg::SRP_HARD) & ~wp_high);
      idle_wel = ~o_write_in_progress & wel_q;
      quad_ok = (cmd_q != fsp_pkg::CMD_QUAD_PAGE_WRITE) | qe_q;
      op_go = idle_wel & ((ex_prog & ~hit & quad_ok) | (ex_erase & ~hit) | (ex_chip & ce_ok));
      sr_go = ex_status_write_cmd & idle_wel & ~sr_locked;
      wel_clr = (~o_write_in_progress & (ex_write_disable_cmd | ex_status_write_cmd | ex_prog | ex_erase | ex_chip)) |
         ex_rst | i_power_cycle;
   end
   // ----------------------------------------------------------------
   // write enable latch and reset arming
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         wel_q <= 1'b0;
      end else if (wel_clr) begin
         wel_q <= 1'b0;
      end else if (ex_wren && !o_write_in_progress) begin
         wel_q <= 1'b1;
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_reset || i_power_cycle) begin
         armed_q <= 1'b0;
      end else if (fe) begin
         armed_q <= ex_arm;
      end
   end
   // ----------------------------------------------------------------
   // non-volatile status fields
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         srp_q <= fsp_pkg::SRP_SOFT;
         bp_q <= 5'h00;
         cmp_q <= 1'b0;
         qe_q <= 1'b0;
         lock_q <= 3'h0;
         drv_q <= fsp_pkg::DRV_RESET;
      end else begin
         if (sr_go && cmd_q == fsp_pkg::CMD_WRITE_SR1) begin
            srp_q[0] <= data_q[fsp_pkg::B_SRP_LO];
            bp_q <= data_q[fsp_pkg::B_BP_LO +: 5];
         end
         if (sr_go && cmd_q == fsp_pkg::CMD_WRITE_SR2) begin
            srp_q[1] <= data_q[fsp_pkg::B_SRP_HI - 8];
            qe_q <= data_q[fsp_pkg::B_QE - 8];
            lock_q <= lock_q | data_q[fsp_pkg::B_LOCK_LO - 8 +: 3];
            cmp_q <= data_q[fsp_pkg::B_CMP - 8];
         end
         if (sr_go && cmd_q == fsp_pkg::CMD_WRITE_SR3) begin
            drv_q <= data_q[fsp_pkg::B_DRV_LO - 16 +: 2];
         end
         if (i_power_cycle && srp_q == fsp_pkg::SRP_LOCKDOWN) begin
            srp_q <= fsp_pkg::SRP_SOFT;
         end
      end
   end
   // ----------------------------------------------------------------
   // busy timer and array operation request
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset || i_power_cycle) begin
         busy_cnt_q <= 24'h000000;
         o_write_in_progress <= 1'b0;
      end else if (op_go || sr_go) begin
         busy_cnt_q <= 24'(BUSY_CYCLES);
         o_write_in_progress <= 1'b1;
      end else if (busy_cnt_q != 24'h000000) begin
         busy_cnt_q <= busy_cnt_q - 24'h000001;
         o_write_in_progress <= (busy_cnt_q != 24'h000001);
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_array_op_start <= 1'b0;
         o_array_op_kind <= fsp_pkg::FSP_OP_PROG;
         o_array_op_addr <= 24'h000000;
         o_status <= 24'h000000;
      end else begin
         o_status <= status_w;
         o_array_op_start <= op_go;
         if (op_go) begin
            o_array_op_addr <= ex_chip ? 24'h000000 : op_lo;
            if (ex_chip) begin
               o_array_op_kind <= fsp_pkg::FSP_OP_CHIP;
            end else if (ex_prog) begin
               o_array_op_kind <= fsp_pkg::FSP_OP_PROG;
            end else if (cmd_q == fsp_pkg::CMD_SECTOR_WIPE) begin
               o_array_op_kind <= fsp_pkg::FSP_OP_SECTOR;
            end else begin
               o_array_op_kind <= fsp_pkg::FSP_OP_BLOCK;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_busy_at_start;
      @(posedge i_clock) disable iff (i_reset)
         o_array_op_start |-> o_write_in_progress && !wel_q;
   endproperty
   a_busy_at_start: assert property (p_busy_at_start)
      else $error("busy flag or latch wrong at op start");
   property p_no_latch_no_op;
      @(posedge i_clock) disable iff (i_reset)
         (ex_prog || ex_erase || ex_chip) && !wel_q |=> !o_array_op_start;
   endproperty
   a_no_latch_no_op: assert property (p_no_latch_no_op)
      else $error("op started with latch clear");
   property p_protected_refused;
      @(posedge i_clock) disable iff (i_reset)
         (ex_prog || ex_erase) && hit |=> !o_array_op_start;
   endproperty
   a_protected_refused: assert property (p_protected_refused)
      else $error("op started inside protected region");
   property p_chip_gate;
      @(posedge i_clock) disable iff (i_reset)
         o_array_op_start && o_array_op_kind == fsp_pkg::FSP_OP_CHIP |-> $past(ce_ok);
   endproperty
   a_chip_gate: assert property (p_chip_gate)
      else $error("chip erase ran with protect bits set");
   property p_hard_lock;
      @(posedge i_clock) disable iff (i_reset)
         ex_status_write_cmd && srp_q == fsp_pkg::SRP_HARD && !wp_high && !o_write_in_progress |=>
         $stable(status_w[22:2]) && !o_write_in_progress;
   endproperty
   a_hard_lock: assert property (p_hard_lock)
      else $error("status written under pin lock");
   property p_lockdown;
      @(posedge i_clock) disable iff (i_reset)
         ex_status_write_cmd && srp_q[1] && !i_power_cycle |=> $stable(status_w[22:2]);
   endproperty
   a_lockdown: assert property (p_lockdown)
      else $error("status written while locked down");
   property p_power_unlock;
      @(posedge i_clock) disable iff (i_reset)
         i_power_cycle && srp_q == fsp_pkg::SRP_LOCKDOWN |=> srp_q == fsp_pkg::SRP_SOFT;
   endproperty
   a_power_unlock: assert property (p_power_unlock)
      else $error("lock-down survived power cycle");
   property p_soft_write;
      @(posedge i_clock) disable iff (i_reset)
         ex_status_write_cmd && srp_q == fsp_pkg::SRP_SOFT && wel_q && !o_write_in_progress
         && !i_power_cycle |=> o_write_in_progress && !wel_q;
   endproperty
   a_soft_write: assert property (p_soft_write)
      else $error("software-protected status write refused");
   property p_busy_ignores;
      @(posedge i_clock) disable iff (i_reset)
         o_write_in_progress && (ex_prog || ex_erase || ex_chip || ex_status_write_cmd) && !i_power_cycle
         |=> !o_array_op_start && $stable(wel_q) && $stable(status_w[22:2]);
   endproperty
   a_busy_ignores: assert property (p_busy_ignores)
      else $error("write accepted while busy");
   property p_quad_gate;
      @(posedge i_clock) disable iff (i_reset)
         ex_prog && cmd_q == fsp_pkg::CMD_QUAD_PAGE_WRITE && !qe_q |=> !o_array_op_start;
   endproperty
   a_quad_gate: assert property (p_quad_gate)
      else $error("quad program ran without quad enable");
   property p_disable_clears;
      @(posedge i_clock) disable iff (i_reset)
         ex_write_disable_cmd && !o_write_in_progress |=> !wel_q [*2];
   endproperty
   a_disable_clears: assert property (p_disable_clears)
      else $error("latch survived write disable");
endmodule

// [rtl/fsp_pkg.sv]
// shared constants and types of the status and write protection block
// assumes a single 25 MHz system clock and a 24-bit array address space
package fsp_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_HZ = 25_000_000;
   localparam int unsigned BUSY_TIME_US = 1000;
   localparam int unsigned BUSY_CYCLES_DFLT = BUSY_TIME_US * (CLOCK_HZ / 1_000_000);
   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   localparam int PIN_SCLK = 0;
   localparam int PIN_CS = 1;
   localparam int PIN_SI = 2;
   localparam int PIN_WP = 3;
   localparam int PIN_HOLD = 4;
   localparam int PIN_COUNT = 5;
   localparam logic [4:0] PIN_IDLE = 5'h1A;
   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_READ_SR1 = 8'h05;
   localparam logic [7:0] CMD_READ_SR2 = 8'h35;
   localparam logic [7:0] CMD_READ_SR3 = 8'h15;
   localparam logic [7:0] CMD_WRITE_SR1 = 8'h01;
   localparam logic [7:0] CMD_WRITE_SR2 = 8'h31;
   localparam logic [7:0] CMD_WRITE_SR3 = 8'h11;
   localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
   localparam logic [7:0] CMD_QUAD_PAGE_WRITE = 8'h32;
   localparam logic [7:0] CMD_FAST_PAGE_WRITE = 8'hF2;
   localparam logic [7:0] CMD_SECTOR_WIPE = 8'h20;
   localparam logic [7:0] CMD_BLOCK32_WIPE = 8'h52;
   localparam logic [7:0] CMD_BLOCK64_WIPE = 8'hD8;
   localparam logic [7:0] CMD_CHIP_WIPE_A = 8'h60;
   localparam logic [7:0] CMD_CHIP_WIPE_B = 8'hC7;
   localparam logic [7:0] CMD_RESET_ARM = 8'h66;
   localparam logic [7:0] CMD_RESET_GO = 8'h99;
   localparam logic [2:0] LEN_SHORT = 3'h1;
   localparam logic [2:0] LEN_SR_WRITE = 3'h2;
   localparam logic [2:0] LEN_ERASE = 3'h4;
   localparam logic [2:0] LEN_PROG = 3'h5;
   // ----------------------------------------------------------------
   // status register layout and reset values
   // ----------------------------------------------------------------
   localparam int B_BP_LO = 2;
   localparam int B_SRP_LO = 7;
   localparam int B_SRP_HI = 8;
   localparam int B_QE = 9;
   localparam int B_LOCK_LO = 11;
   localparam int B_CMP = 14;
   localparam int B_DRV_LO = 21;
   localparam logic [1:0] SRP_SOFT = 2'h0;
   localparam logic [1:0] SRP_HARD = 2'h1;
   localparam logic [1:0] SRP_LOCKDOWN = 2'h2;
   localparam logic [1:0] DRV_RESET = 2'h1;
   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam logic [23:0] ADDR_TOP = 24'h7FFFFF;
   localparam logic [23:0] UNIT_LARGE = 24'h020000;
   localparam logic [23:0] UNIT_SMALL = 24'h001000;
   localparam logic [23:0] MASK_PAGE = 24'h0000FF;
   localparam logic [23:0] MASK_SECTOR = 24'h000FFF;
   localparam logic [23:0] MASK_BLOCK32 = 24'h007FFF;
   localparam logic [23:0] MASK_BLOCK64 = 24'h00FFFF;
   typedef enum logic [1:0] {FSP_OP_PROG, FSP_OP_SECTOR, FSP_OP_BLOCK, FSP_OP_CHIP} fsp_op_t;
endpackage

// [rtl/fsp_prot_if.sv]
// protection settings in, protected address range out
// assumes one decoder and one user on the same clock
`timescale 1ns/1ps
interface fsp_prot_if;
   logic [4:0] block_protect;
   logic protect_complement;
   logic prot_en;
   logic [23:0] prot_lo;
   logic [23:0] prot_hi;
   modport decoder (input block_protect, input protect_complement,
      output prot_en, output prot_lo, output prot_hi);
   modport user (output block_protect, output protect_complement,
      input prot_en, input prot_lo, input prot_hi);
endinterface

// [rtl/fsp_region_decode.sv]
// maps block protect and complement bits to one protected address range
// assumes the range is always a prefix or a suffix of the array
`timescale 1ns/1ps
module fsp_region_decode (
   fsp_prot_if.decoder prot
);
   logic [2:0] code;
   logic [2:0] shift;
   logic [23:0] size;
   logic [23:0] last;
   logic upper;
   always_comb begin
      code = prot.block_protect[2:0];
      shift = (prot.block_protect[4] && code >= 3'h4) ? 3'h3 : code - 3'h1;
      size = prot.block_protect[4] ? (fsp_pkg::UNIT_SMALL << shift) :
         (fsp_pkg::UNIT_LARGE << shift);
      last = size - 24'h000001;
      upper = ~prot.block_protect[3];
      prot.prot_lo = 24'h000000;
      prot.prot_hi = fsp_pkg::ADDR_TOP;
      prot.prot_en = 1'b1;
      if (code == 3'h0 || code == 3'h7) begin
         prot.prot_en = (code == 3'h7) ^ prot.protect_complement;
      end else if (!prot.protect_complement) begin
         if (upper) begin
            prot.prot_lo = fsp_pkg::ADDR_TOP - last;
         end else begin
            prot.prot_hi = last;
         end
      end else begin
         if (upper) begin
            prot.prot_hi = fsp_pkg::ADDR_TOP - size;
         end else begin
            prot.prot_lo = size;
         end
      end
   end
endmodule

// [test/fsp_host_model.sv]
// spi host model issuing status and program frames
// assumes the device samples sclk with its own clock
`timescale 1ns/1ps
module fsp_host_model (
   input wire logic i_clock,
   input wire logic i_so,
   input wire logic i_so_oe,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_si
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end
   // msb first, 320 ns per bit, sclk still between frames
   task automatic frame(input logic [47:0] d, input int n, output logic [7:0] rd);
      rd = 8'h00;
      @(negedge i_clock) o_cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         o_si = d[i];
         repeat (4) @(negedge i_clock);
         o_sclk = 1'b1;
         repeat (4) @(negedge i_clock);
         rd = {rd[6:0], i_so_oe ? i_so : 1'bx};
         o_sclk = 1'b0;
      end
      // released data line does not keep its last level
      o_si = ~o_si;
      repeat (4) @(negedge i_clock);
      o_cs_n = 1'b1;
      repeat (12) @(negedge i_clock);
   endtask
endmodule

// [test/tb_fsp_status_ctrl.sv]
// self-checking bench of the status and write protection block
// assumes whole byte-aligned frames from the host model
`timescale 1ns/1ps
module tb_fsp_status_ctrl;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic i_power_cycle = 1'b0;
   logic i_wp_n = 1'b1;
   logic i_hold_n = 1'b1;
   logic sclk, cs_n, si, so, so_oe, write_in_progress, qe, start;
   logic [1:0] kind;
   logic [23:0] addr, st;
   logic [7:0] rd;
   int errors = 0;
   int samples_checked = 0;
   int starts = 0;
   fsp_status_ctrl #(.BUSY_CYCLES(300)) u_dut (.i_clock(i_clock), .i_reset(i_reset),
      .i_power_cycle(i_power_cycle), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
      .i_wp_n(i_wp_n), .i_hold_n(i_hold_n), .o_so(so), .o_so_oe(so_oe),
      .o_write_in_progress(write_in_progress), .o_quad_lane_enable(qe), .o_array_op_start(start),
      .o_array_op_kind(kind), .o_array_op_addr(addr), .o_status(st));
   fsp_host_model u_host (.i_clock(i_clock), .i_so(so), .i_so_oe(so_oe), .o_sclk(sclk),
      .o_cs_n(cs_n), .o_si(si));
   initial begin
      forever #20 i_clock = ~i_clock;
   end
   always @(negedge i_clock) begin
      if (start === 1'b1) starts++;
   end
   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tx(input logic [47:0] d, input int n);
      u_host.frame(d, n, rd);
   endtask
   task automatic wr(input logic [47:0] d, input int n);
      tx(48'h06, 8);
      tx(d, n);
      for (int i = 0; i < 400 && write_in_progress !== 1'b0; i++) @(negedge i_clock);
   endtask
   task automatic t_latch;
      tx(48'h06, 8);
      chk("wel_set", st[1], 1'b1);
      tx(48'h04, 8);
      chk("wel_clear", st[1], 1'b0);
      tx(48'h0104, 16);
      chk("bp_no_wel", st[6:2], 5'h00);
      tx(48'h06, 8);
      tx(48'h0104, 16);
      chk("wip_busy", write_in_progress, 1'b1);
      wr(48'h0100, 16);
      chk("bp_busy", st[6:2], 5'h01);
      chk("wip_done", write_in_progress, 1'b0);
      chk("wel_after", st[1], 1'b0);
      tx(48'h0500, 16);
      chk("read_sr1", rd, 8'h04);
      tx(48'h06, 8);
      tx(48'h66, 8);
      tx(48'h99, 8);
      chk("soft_reset", st[1], 1'b0);
   endtask
   task automatic t_region;
      wr(48'h027E0000AA, 40);
      chk("top_refused", starts, 0);
      wr(48'h0200100055, 40);
      chk("low_taken", starts, 1);
      chk("kind_addr", {kind, addr[21:0]}, {2'h0, 22'h001000});
      wr(48'h60, 8);
      chk("chip_refused", starts, 1);
      wr(48'h3140, 16);
      wr(48'h0200100055, 40);
      chk("cmp_low", starts, 1);
      wr(48'h027E000055, 40);
      chk("cmp_top", starts, 2);
      wr(48'h327E100055, 40);
      chk("quad_refused", starts, 2);
      wr(48'h207E1000, 32);
      chk("sector_taken", starts, 3);
      chk("sector_kind", kind, 2'h1);
      chk("sector_addr", addr, 24'h7E1000);
   endtask
   task automatic t_srp;
      i_hold_n = 1'b0;
      tx(48'h06, 8);
      chk("hold_gate", st[1], 1'b0);
      i_hold_n = 1'b1;
      wr(48'h0180, 16);
      i_wp_n = 1'b0;
      wr(48'h0104, 16);
      chk("hard_lock", st[8:2], 7'h20);
      i_wp_n = 1'b1;
      wr(48'h0100, 16);
      chk("hard_open", st[8:2], 7'h00);
      wr(48'h3101, 16);
      chk("lockdown", st[8:7], 2'h2);
      tx(48'h3500, 16);
      chk("read_sr2", rd, 8'h01);
      wr(48'h0104, 16);
      chk("lock_bp", st[6:2], 5'h00);
      @(negedge i_clock) i_power_cycle = 1'b1;
      @(negedge i_clock) i_power_cycle = 1'b0;
      repeat (4) @(negedge i_clock);
      chk("power_cycle", st[8:7], 2'h0);
      wr(48'h3102, 16);
      chk("quad_on", qe, 1'b1);
   endtask
   task automatic print_verdict;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      errors++;
      print_verdict();
   end
   initial begin
      repeat (10) @(negedge i_clock);
      i_reset = 1'b0;
      repeat (4) @(negedge i_clock);
      chk("reset_status", st, 24'h200000);
      chk("reset_quad", qe, 1'b0);
      t_latch();
      t_region();
      t_srp();
      print_verdict();
   end
endmodule
